// [hw/urls_defs.svh]
`ifndef URLS_DEFS_SVH
`define URLS_DEFS_SVH

// register byte addresses
`define URLS_LSR_ADDR 32'he000c014
`define URLS_FCR_ADDR 32'he000c008
`define URLS_IIR_ADDR 32'he000c008
`define URLS_IST_ADDR 32'he000c040
`define URLS_IMSK_ADDR 32'he000c044

// line status field positions
`define URLS_LSR_READY_BIT 0
`define URLS_LSR_OE_BIT 1
`define URLS_LSR_PAR_BIT 2

// fifo control field positions
`define URLS_FCR_EN_BIT 0
`define URLS_FCR_RXRST_BIT 1
`define URLS_FCR_TXRST_BIT 2
`define URLS_FCR_TRIG_LO 6
`define URLS_FCR_TRIG_HI 7

// interrupt status / mask field positions
`define URLS_INT_OE_BIT 0
`define URLS_INT_PAR_BIT 1
`define URLS_INT_WIDTH 2

// reset values
`define URLS_LSR_RESET 8'h00
`define URLS_FCR_EN_RESET 1'h0
`define URLS_FCR_TRIG_RESET 2'h0
`define URLS_IMSK_RESET 2'h0

// interrupt identification codes
`define URLS_IIR_NONE 4'h1
`define URLS_IIR_LINE 4'h6
`define URLS_IIR_DATA 4'h4

`endif

// [hw/urls_pkg.sv]
package urls_pkg;

  // error flags; parity error is kept for the character at the head of the queue, overrun for the queue
  typedef struct packed {
    logic parity_error;
    logic overrun;
  } urls_err_type;

  // line status register as software sees it
  typedef struct packed {
    logic [4:0] unused;
    logic parity_error;
    logic overrun;
    logic rx_data_ready;
  } urls_lsr_type;

  // fifo control settings held by the block
  typedef struct packed {
    logic [1:0] rx_trigger;
    logic enable;
  } urls_fcr_type;

endpackage

// [hw/urls_sticky.sv]
`timescale 1ns/100ps

module urls_sticky #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] next_q;

  // set wins so an event in the clearing cycle survives
  always_comb
  begin
    next_q = (q_o & ~clr_i) | set_i;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      q_o <= '0;
    end
    else
    begin
      q_o <= next_q;
    end
  end

endmodule

// [hw/urls_iir_encode.sv]
`timescale 1ns/100ps
`include "urls_defs.svh"

module urls_iir_encode (
  input wire logic line_err_i,
  input wire logic data_avail_i,
  output logic [3:0] code_o
);

  // line errors outrank received data
  always_comb
  begin
    if (line_err_i)
    begin
      code_o = `URLS_IIR_LINE;
    end
    else if (data_avail_i)
    begin
      code_o = `URLS_IIR_DATA;
    end
    else
    begin
      code_o = `URLS_IIR_NONE;
    end
  end

endmodule

// [hw/urls_line_status.sv]
// Our own choice: strobed register access.
`timescale 1ns/100ps
`include "urls_defs.svh"

// Summary of operation
// - data ready bit 0 follows a non-empty receive fifo, clears when it empties.
// - overrun bit 1 sets when a character completes into a full fifo.
// - on overrun the fifo keeps its contents and the new character is dropped.
// - reading the line status register clears the overrun bit.
// - parity error bit 2 sets when a received parity bit is wrong.
// - reading the line status register clears the parity error bit.
// - parity error is reported for the character at the head of the fifo.
// - when the parity error shows depends on the fifo enable bit.
// - line status register is read only; its flags read 0 after reset.
// - overrun or parity error raises top priority line interrupt, code 0110.
// - fifo enable bit is an active high enable for both fifos.
module urls_line_status (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic rx_char_done_i,
  input wire logic rx_parity_bad_i,
  input wire logic fifo_empty_i,
  input wire logic fifo_full_i,
  input wire logic head_load_i,
  input wire logic head_parity_bad_i,
  output logic fifo_push_o,
  output logic rx_fifo_clear_o,
  output logic tx_fifo_clear_o,
  output logic fifo_enable_o,
  output logic [1:0] rx_trigger_o,
  output logic irq_o
);

  urls_pkg::urls_err_type err_q;
  urls_pkg::urls_err_type err_set;
  urls_pkg::urls_err_type err_clr;
  urls_pkg::urls_lsr_type lsr_view;
  urls_pkg::urls_fcr_type fcr_q;
  urls_pkg::urls_fcr_type next_fcr;
  logic [`URLS_INT_WIDTH-1:0] ist_q;
  logic [`URLS_INT_WIDTH-1:0] ist_set;
  logic [`URLS_INT_WIDTH-1:0] ist_clr;
  logic [`URLS_INT_WIDTH-1:0] mask_q;
  logic [`URLS_INT_WIDTH-1:0] next_mask;
  logic [31:0] next_rdata;
  logic next_rx_clear;
  logic next_tx_clear;
  logic rx_clear_q;
  logic tx_clear_q;
  logic lsr_rd;
  logic fcr_wr;
  logic ist_wr;
  logic imsk_wr;
  logic oe_event;
  logic par_event;
  logic [3:0] iir_code;

  // address decode; the control word shares its address with the id read
  always_comb
  begin
    lsr_rd = rd_i && (addr_i == `URLS_LSR_ADDR);
    fcr_wr = wr_i && (addr_i == `URLS_FCR_ADDR);
    ist_wr = wr_i && (addr_i == `URLS_IST_ADDR);
    imsk_wr = wr_i && (addr_i == `URLS_IMSK_ADDR);
  end

  // character completion and overrun
  always_comb
  begin
    oe_event = rx_char_done_i && fifo_full_i;
    fifo_push_o = rx_char_done_i && !fifo_full_i;
  end

  // with the fifo on, a bad character waits until it reaches the head;
  // with it off, the single holding slot is the head at once
  always_comb
  begin
    if (fcr_q.enable)
    begin
      par_event = head_load_i && head_parity_bad_i;
    end
    else
    begin
      par_event = rx_char_done_i && rx_parity_bad_i && !fifo_full_i;
    end
  end

  // error flags; only a status read clears them, a write has no effect
  always_comb
  begin
    err_set.overrun = oe_event;
    err_set.parity_error = par_event;
    err_clr.overrun = lsr_rd;
    err_clr.parity_error = lsr_rd;
  end

  // the read returns the flags as they stand, so clearing them
  // in the same cycle removes exactly what software saw
  urls_sticky #(
    .WIDTH(2)
  ) u_err_flags (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .set_i(err_set),
    .clr_i(err_clr),
    .q_o(err_q)
  );

  // interrupt status, write one to clear
  always_comb
  begin
    ist_set = '0;
    ist_set[`URLS_INT_OE_BIT] = oe_event;
    ist_set[`URLS_INT_PAR_BIT] = par_event;
    ist_clr = ist_wr ? wdata_i[`URLS_INT_WIDTH-1:0] : '0;
  end

  urls_sticky #(
    .WIDTH(`URLS_INT_WIDTH)
  ) u_int_status (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .set_i(ist_set),
    .clr_i(ist_clr),
    .q_o(ist_q)
  );

  urls_iir_encode u_iir (
    .line_err_i(err_q.overrun || err_q.parity_error),
    .data_avail_i(!fifo_empty_i),
    .code_o(iir_code)
  );

  // line status view; upper bits are not kept by this block
  always_comb
  begin
    lsr_view.unused = 5'h00;
    lsr_view.parity_error = err_q.parity_error;
    lsr_view.overrun = err_q.overrun;
    lsr_view.rx_data_ready = !fifo_empty_i;
  end

  // control registers and fifo clear pulses
  always_comb
  begin
    next_fcr = fcr_q;
    next_mask = mask_q;
    next_rx_clear = 1'b0;
    next_tx_clear = 1'b0;
    if (fcr_wr)
    begin
      next_fcr.enable = wdata_i[`URLS_FCR_EN_BIT];
      // any change of the enable empties both fifos
      if (wdata_i[`URLS_FCR_EN_BIT] != fcr_q.enable)
      begin
        next_rx_clear = 1'b1;
        next_tx_clear = 1'b1;
      end
      // the other fields only take when the same write sets the enable bit
      if (wdata_i[`URLS_FCR_EN_BIT])
      begin
        next_fcr.rx_trigger = wdata_i[`URLS_FCR_TRIG_HI:`URLS_FCR_TRIG_LO];
        if (wdata_i[`URLS_FCR_RXRST_BIT])
        begin
          next_rx_clear = 1'b1;
        end
        if (wdata_i[`URLS_FCR_TXRST_BIT])
        begin
          next_tx_clear = 1'b1;
        end
      end
    end
    if (imsk_wr)
    begin
      next_mask = wdata_i[`URLS_INT_WIDTH-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fcr_q.enable <= `URLS_FCR_EN_RESET;
      fcr_q.rx_trigger <= `URLS_FCR_TRIG_RESET;
      mask_q <= `URLS_IMSK_RESET;
      rx_clear_q <= 1'b0;
      tx_clear_q <= 1'b0;
    end
    else
    begin
      fcr_q <= next_fcr;
      mask_q <= next_mask;
      rx_clear_q <= next_rx_clear;
      tx_clear_q <= next_tx_clear;
    end
  end

  // read data only in the cycle after the strobe, zero otherwise
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (rd_i)
    begin
      unique case (addr_i)
        `URLS_LSR_ADDR:
        begin
          next_rdata[7:0] = lsr_view;
        end
        `URLS_IIR_ADDR:
        begin
          next_rdata[3:0] = iir_code;
        end
        `URLS_IST_ADDR:
        begin
          next_rdata[`URLS_INT_WIDTH-1:0] = ist_q;
        end
        `URLS_IMSK_ADDR:
        begin
          next_rdata[`URLS_INT_WIDTH-1:0] = mask_q;
        end
        default:
        begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= 32'h00000000;
    end
    else
    begin
      rdata_o <= next_rdata;
    end
  end

  assign rx_fifo_clear_o = rx_clear_q;
  assign tx_fifo_clear_o = tx_clear_q;
  assign fifo_enable_o = fcr_q.enable;
  assign rx_trigger_o = fcr_q.rx_trigger;
  assign irq_o = |(ist_q & mask_q);

  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  AST_READY_FOLLOWS: assert property (
    lsr_rd |=> rdata_o[`URLS_LSR_READY_BIT] == !$past(fifo_empty_i)
  ) else $error("data ready bit does not follow fifo empty");

  AST_OE_SETS: assert property (
    (rx_char_done_i && fifo_full_i) |=> err_q.overrun
  ) else $error("overrun not flagged on full fifo");

  AST_DISCARD: assert property (
    (rx_char_done_i && fifo_full_i) |-> !fifo_push_o
  ) else $error("character pushed into full fifo");

  AST_OE_CLEARS: assert property (
    (lsr_rd && err_q.overrun && !oe_event)
      |=> !err_q.overrun
  ) else $error("overrun not cleared by status read");

  AST_PAR_NOFIFO: assert property (
    (!fcr_q.enable && rx_char_done_i && rx_parity_bad_i && !fifo_full_i)
      |=> err_q.parity_error
  ) else $error("parity error not flagged on reception");

  AST_PAR_CLEARS: assert property (
    (lsr_rd && !par_event) |=> !err_q.parity_error
  ) else $error("parity error not cleared by status read");

  AST_PAR_AT_HEAD: assert property (
    (fcr_q.enable && head_load_i && head_parity_bad_i) |=> err_q.parity_error
  ) else $error("parity error missing when bad character reaches head");

  AST_PAR_WAITS: assert property (
    (fcr_q.enable && !head_load_i && !err_q.parity_error) |=> !err_q.parity_error
  ) else $error("parity error shown before character reached head");

  AST_READ_ONLY: assert property (
    (wr_i && addr_i == `URLS_LSR_ADDR && err_q.overrun) |=> err_q.overrun
  ) else $error("write altered line status");

  AST_LINE_IRQ: assert property (
    (err_q.overrun || err_q.parity_error) |-> iir_code == `URLS_IIR_LINE
  ) else $error("line status interrupt code wrong");

  AST_FIFO_EN: assert property (
    (fcr_wr && wdata_i[0] != fcr_q.enable)
      |=> fifo_enable_o == $past(wdata_i[0]) && rx_fifo_clear_o && tx_fifo_clear_o
  ) else $error("fifo enable change not applied or fifos not cleared");

  AST_SET_WINS: assert property (
    (lsr_rd && oe_event)
      |=> err_q.overrun && ist_q[`URLS_INT_OE_BIT]
  ) else $error("overrun lost in clearing cycle");

endmodule

// [testbench/urls_rx_model.sv]
`timescale 1ns/100ps

module urls_rx_model (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic push_i,
  input wire logic bad_i,
  input wire logic pop_i,
  input wire logic clear_i,
  output logic empty_o,
  output logic full_o,
  output logic head_load_o,
  output logic head_bad_o
);
  // two-deep receive queue, entry 0 is the head
  logic [1:0] cnt;
  logic [1:0] tag;
  assign empty_o = cnt == 2'h0;
  assign full_o = cnt == 2'h2;
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt <= 2'h0;
      tag <= 2'h0;
      head_load_o <= 1'b0;
      head_bad_o <= 1'b0;
    end
    else
    begin
      head_load_o <= 1'b0;
      if (clear_i)
        cnt <= 2'h0;
      else if (push_i)
      begin
        // push only offered when not full, so contents never overwritten
        cnt <= cnt + 2'h1;
        tag[cnt[0]] <= bad_i;
        head_load_o <= cnt == 2'h0;
        head_bad_o <= bad_i;
      end
      else if (pop_i && cnt != 2'h0)
      begin
        cnt <= cnt - 2'h1;
        tag[0] <= tag[1];
        head_load_o <= cnt == 2'h2;
        head_bad_o <= tag[1];
      end
    end
  end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/100ps
`include "urls_defs.svh"

module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic done = 1'b0;
  logic pbad = 1'b0;
  logic pop = 1'b0;
  logic [31:0] rdata;
  logic empty, full, hl, hb, push, rclr, tclr, fen, irq;
  logic [1:0] trig;
  int mismatches = 0;
  int samples_checked = 0;

  always #50 clk = ~clk;

  urls_line_status u_urls_line_status (
    .ref_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_char_done_i(done),
    .rx_parity_bad_i(pbad), .fifo_empty_i(empty), .fifo_full_i(full),
    .head_load_i(hl), .head_parity_bad_i(hb), .fifo_push_o(push),
    .rx_fifo_clear_o(rclr), .tx_fifo_clear_o(tclr), .fifo_enable_o(fen),
    .rx_trigger_o(trig), .irq_o(irq)
  );

  urls_rx_model u_urls_rx_model (
    .ref_clk_i(clk), .nrst_i(nrst), .push_i(push), .bad_i(pbad),
    .pop_i(pop), .clear_i(rclr), .empty_o(empty), .full_o(full),
    .head_load_o(hl), .head_bad_o(hb)
  );

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t read %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_reg(rdata, e);
  endtask

  task automatic send(input logic b);
    @(posedge clk);
    done <= 1'b1;
    pbad <= b;
    @(posedge clk);
    done <= 1'b0;
    pbad <= 1'b0;
    #1;
  endtask

  task automatic pop1;
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    rchk(`URLS_LSR_ADDR, 32'h0);
    chk_bit(irq, 1'b0);
    rchk(`URLS_IIR_ADDR, 32'h1);
    wr_reg(`URLS_FCR_ADDR, 32'hc1);
    chk_bit(rclr, 1'b1);
    chk_bit(tclr, 1'b1);
    chk_bit(fen, 1'b1);
    chk_reg({30'h0, trig}, 32'h3);
    wr_reg(`URLS_LSR_ADDR, 32'hff);
    rchk(`URLS_LSR_ADDR, 32'h0);
    rchk(32'he000c0f0, 32'h0);
  endtask

  task automatic t_ready;
    send(1'b0);
    rchk(`URLS_LSR_ADDR, 32'h1);
    pop1;
    rchk(`URLS_LSR_ADDR, 32'h0);
  endtask

  task automatic t_overrun;
    wr_reg(`URLS_IMSK_ADDR, 32'h1);
    send(1'b0);
    send(1'b0);
    @(posedge clk);
    done <= 1'b1;
    #1;
    chk_bit(push, 1'b0);
    @(posedge clk);
    done <= 1'b0;
    #1;
    chk_bit(full, 1'b1);
    chk_bit(irq, 1'b1);
    wr_reg(`URLS_LSR_ADDR, 32'h0);
    rchk(`URLS_IIR_ADDR, 32'h6);
    rchk(`URLS_LSR_ADDR, 32'h3);
    rchk(`URLS_LSR_ADDR, 32'h1);
    rchk(`URLS_IIR_ADDR, 32'h4);
    wr_reg(`URLS_IST_ADDR, 32'h1);
    chk_bit(irq, 1'b0);
  endtask

  // read and overrun land on one edge; the new flag must survive
  task automatic t_same;
    @(posedge clk);
    done <= 1'b1;
    addr <= `URLS_LSR_ADDR;
    rd <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    rd <= 1'b0;
    #1;
    chk_reg(rdata, 32'h1);
    rchk(`URLS_LSR_ADDR, 32'h3);
    wr_reg(`URLS_IST_ADDR, 32'h1);
    pop1;
    pop1;
  endtask

  task automatic t_par_fifo;
    send(1'b0);
    send(1'b1);
    rchk(`URLS_LSR_ADDR, 32'h1);
    pop1;
    rchk(`URLS_LSR_ADDR, 32'h5);
    chk_bit(irq, 1'b0);
    rchk(`URLS_LSR_ADDR, 32'h1);
    pop1;
  endtask

  task automatic t_par_direct;
    wr_reg(`URLS_FCR_ADDR, 32'h0);
    chk_bit(fen, 1'b0);
    chk_bit(rclr, 1'b1);
    chk_reg({30'h0, trig}, 32'h3);
    send(1'b1);
    rchk(`URLS_LSR_ADDR, 32'h5);
    wr_reg(`URLS_IMSK_ADDR, 32'h3);
    chk_bit(irq, 1'b1);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_ready;
    t_overrun;
    t_same;
    t_par_fifo;
    t_par_direct;
    conclude;
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    #1000000;
    mismatches++;
    conclude;
  end
endmodule
